//--- wdf_ctrl_top.sv
// Behaviour
// - reboot keeps software settings or reverts to straps
// - restart request reloads watchdog, counting continues
// - expiry sets flag; zero period clears it
// - period code: off, then 2s per step up to 30s (codes 1 to 15)
// - direct mode uses N and M registers
// - N split across two registers, M low
// - ratio follows straps or software select
// - override bit picks strap or software select
// - direct enable bit, resets to zero
// - output equals gear times N over M
// - gear chosen by active select value
`timescale 1ns/1ns
module wdf_ctrl_top
  import wdf_pkg::*;
#(
  parameter int TICK_CYCLES = WD_TICK_CYCLES,
  parameter logic [6:0] DEV_ADDR = SMB_DEV_ADDR
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic SMB_CLK,
  input wire logic SMB_DATA_IN,
  output logic SMB_DATA_OUT,
  output logic SMB_DATA_OE_N,
  input wire logic [4:0] STRAP_FS,
  input wire logic SYS_REBOOT,
  output logic [4:0] FREQ_SELECT,
  output logic DIRECT_EN,
  output logic [8:0] SYNTH_N,
  output logic [6:0] SYNTH_M,
  output logic WD_TIMEOUT,
  output logic WD_EXPIRE
);
  localparam int TW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2) begin : g_tick_check
    $error("TICK_CYCLES must be at least 2");
  end

  logic [7:0] rd_addr, rd_data, wr_addr, wr_data;
  logic wr_stb, sda_out, sda_oe_n;
  logic [4:0] strap_m_r, strap_s_r;
  logic boot_m_r, boot_s_r, boot_d_r, reboot;
  logic [1:0] settle_r, settle_nxt;
  logic [4:0] strap_r, strap_nxt, fsel_r, fsel_nxt;
  logic [7:0] wdog_r, wdog_nxt, nhi_r, nhi_nxt, nlo_m_r, nlo_m_nxt, src_r, src_nxt;
  logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
  logic [4:0] sec_cnt_r, sec_cnt_nxt, limit;
  logic restart, tick, expire, period_on;
  logic [4:0] freq_sel_r, freq_sel_nxt;
  logic direct_r, direct_nxt, expire_r, sda_oe_n_r, sda_out_r;

  wdf_smb_slave #(.DEV_ADDR(DEV_ADDR)) u_smb (
    .clk(REF_CLK),
    .srst(SRST),
    .scl_pin(SMB_CLK),
    .sda_pin(SMB_DATA_IN),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // pin synchronisers; third reboot stage finds the rising edge
  // strap stages keep sampling through reset so the latch sees settled pins
  always_ff @(posedge REF_CLK) begin
    strap_m_r <= STRAP_FS;
    strap_s_r <= strap_m_r;
    if (SRST) begin
      {boot_m_r, boot_s_r, boot_d_r} <= 3'h0;
    end else begin
      {boot_m_r, boot_s_r, boot_d_r} <= {SYS_REBOOT, boot_m_r, boot_s_r};
    end
  end

  assign reboot = boot_s_r & ~boot_d_r;
  assign period_on = wdog_r[WDOG_PERIOD_MSB:0] != WD_PERIOD_OFF;
  assign limit = WD_STEP_SEC * {1'b0, wdog_r[WDOG_PERIOD_MSB:0]};
  assign tick = period_on && (tick_cnt_r == TICK_LAST);
  assign expire = tick && (sec_cnt_r + 5'h01 >= limit);
  // only a 0-to-1 write of the restart bit reloads
  assign restart = wr_stb && wr_addr == REG_WDOG && wr_data[WDOG_RESTART_BIT]
                   && !wdog_r[WDOG_RESTART_BIT];

  // read mux; the timeout flag is readable state
  always_comb begin
    unique case (rd_addr)
      REG_FSEL: rd_data = {3'h0, fsel_r};
      REG_WDOG: rd_data = wdog_r;
      REG_NHI: rd_data = nhi_r;
      REG_NLO_M: rd_data = nlo_m_r;
      REG_SRC: rd_data = src_r;
      default: rd_data = RD_UNMAPPED;
    endcase
  end

  // strap latch after reset settle and at each reboot
  always_comb begin
    settle_nxt = settle_r;
    strap_nxt = strap_r;
    if (settle_r != STRAP_SETTLE) begin
      settle_nxt = settle_r + 2'h1;
      if (settle_r + 2'h1 == STRAP_SETTLE) begin
        strap_nxt = strap_s_r;
      end
    end else if (reboot) begin
      strap_nxt = strap_s_r;
    end
  end

  // register writes and reboot recovery
  always_comb begin
    fsel_nxt = fsel_r;
    wdog_nxt = wdog_r;
    nhi_nxt = nhi_r;
    nlo_m_nxt = nlo_m_r;
    src_nxt = src_r;
    if (wr_stb) begin
      unique case (wr_addr)
        REG_FSEL: fsel_nxt = wr_data[4:0];
        REG_WDOG: begin
          // test bit is stored only; host keeps it zero
          wdog_nxt = wr_data;
          wdog_nxt[WDOG_ALARM_BIT] = wdog_r[WDOG_ALARM_BIT];
          if (wr_data[WDOG_PERIOD_MSB:0] == WD_PERIOD_OFF) begin
            wdog_nxt[WDOG_ALARM_BIT] = 1'b0;
          end
        end
        REG_NHI: nhi_nxt = wr_data;
        REG_NLO_M: nlo_m_nxt = wr_data;
        REG_SRC: src_nxt = wr_data;
        default: ;
      endcase
    end
    // expiry wins over a clearing write in the same cycle
    if (expire) begin
      wdog_nxt[WDOG_ALARM_BIT] = 1'b1;
    end
    if (reboot && !wdog_r[WDOG_RECOVER_BIT]) begin
      src_nxt[SRC_OVERRIDE_BIT] = 1'b0;
      src_nxt[SRC_DIRECT_BIT] = 1'b0;
    end
  end

  // watchdog second counter
  always_comb begin
    tick_cnt_nxt = tick_cnt_r;
    sec_cnt_nxt = sec_cnt_r;
    if (!period_on || restart) begin
      tick_cnt_nxt = '0;
      sec_cnt_nxt = 5'h00;
    end else if (tick) begin
      tick_cnt_nxt = '0;
      sec_cnt_nxt = expire ? 5'h00 : sec_cnt_r + 5'h01;
    end else begin
      tick_cnt_nxt = tick_cnt_r + TW'(1);
    end
  end

  // active select doubles as ratio and gear index
  always_comb begin
    freq_sel_nxt = src_r[SRC_OVERRIDE_BIT] ? fsel_r : strap_r;
    direct_nxt = src_r[SRC_DIRECT_BIT];
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      settle_r <= 2'h0;
      strap_r <= 5'h00;
      fsel_r <= RST_FSEL;
      wdog_r <= RST_WDOG;
      nhi_r <= RST_NHI;
      nlo_m_r <= RST_NLO_M;
      src_r <= RST_SRC;
      tick_cnt_r <= '0;
      sec_cnt_r <= 5'h00;
      freq_sel_r <= 5'h00;
      direct_r <= 1'b0;
      expire_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      sda_out_r <= 1'b0;
    end else begin
      settle_r <= settle_nxt;
      strap_r <= strap_nxt;
      fsel_r <= fsel_nxt;
      wdog_r <= wdog_nxt;
      nhi_r <= nhi_nxt;
      nlo_m_r <= nlo_m_nxt;
      src_r <= src_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      sec_cnt_r <= sec_cnt_nxt;
      freq_sel_r <= freq_sel_nxt;
      direct_r <= direct_nxt;
      expire_r <= expire;
      sda_oe_n_r <= sda_oe_n;
      sda_out_r <= sda_out;
    end
  end

  assign SMB_DATA_OUT = sda_out_r;
  assign SMB_DATA_OE_N = sda_oe_n_r;
  assign FREQ_SELECT = freq_sel_r;
  assign DIRECT_EN = direct_r;
  assign SYNTH_N = {nhi_r, nlo_m_r[NLO_N0_BIT]};
  assign SYNTH_M = nlo_m_r[NLO_M_MSB:0];
  assign WD_TIMEOUT = wdog_r[WDOG_ALARM_BIT];
  assign WD_EXPIRE = expire_r;
endmodule

//--- wdf_pkg.sv
package wdf_pkg;
  // reference time base
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int WD_TICK_SEC = 1;
  localparam int WD_TICK_CYCLES = CLK_FREQ_HZ * WD_TICK_SEC;
  // seconds per step of the timeout period code
  localparam logic [4:0] WD_STEP_SEC = 5'h02;
  localparam logic [3:0] WD_PERIOD_OFF = 4'h0;

  // register offsets (serial command codes)
  localparam logic [7:0] REG_FSEL = 8'h08;
  localparam logic [7:0] REG_WDOG = 8'h0B;
  localparam logic [7:0] REG_NHI = 8'h0C;
  localparam logic [7:0] REG_NLO_M = 8'h0D;
  localparam logic [7:0] REG_SRC = 8'h0E;

  // watchdog_recovery_ctrl fields
  localparam int WDOG_TEST_BIT = 7;
  localparam int WDOG_RECOVER_BIT = 6;
  localparam int WDOG_RESTART_BIT = 5;
  localparam int WDOG_ALARM_BIT = 4;
  localparam int WDOG_PERIOD_MSB = 3;
  // freq_source_ctrl fields
  localparam int SRC_OVERRIDE_BIT = 7;
  localparam int SRC_DIRECT_BIT = 0;
  // synth_n_low_m fields
  localparam int NLO_N0_BIT = 7;
  localparam int NLO_M_MSB = 6;

  // reset values
  localparam logic [7:0] RST_WDOG = 8'h00;
  localparam logic [7:0] RST_NHI = 8'h00;
  localparam logic [7:0] RST_NLO_M = 8'h00;
  localparam logic [7:0] RST_SRC = 8'h40;
  localparam logic [4:0] RST_FSEL = 5'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // serial slave address, value arbitrary
  localparam logic [6:0] SMB_DEV_ADDR = 7'h2A;
  localparam logic [3:0] SMB_BYTE_BITS = 4'h8;
  // synchroniser wait before the strap pins are valid
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_CMD, S_WDATA, S_ACK, S_RDATA, S_RACK
  } wdf_smb_state_t;
endpackage

//--- wdf_smb_slave.sv
`timescale 1ns/1ns
module wdf_smb_slave
  import wdf_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = SMB_DEV_ADDR
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
  wdf_smb_state_t state_r, state_nxt, after_r, after_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt, cmd_r, cmd_nxt, wr_addr_r, wr_addr_nxt, wr_data_r, wr_data_nxt;
  logic oe_n_r, oe_n_nxt, ack_ok_r, ack_ok_nxt, wr_stb_r, wr_stb_nxt;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // two-flop synchronisers plus one delay stage for edge finding
  always_ff @(posedge clk) begin
    if (srst) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
    end else begin
      {scl_m_r, scl_s_r, scl_d_r} <= {scl_pin, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {sda_pin, sda_m_r, sda_s_r};
    end
  end

  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_cond = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_cond = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // byte write and byte read with auto-increment
  always_comb begin
    state_nxt = state_r;
    after_nxt = after_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    cmd_nxt = cmd_r;
    oe_n_nxt = oe_n_r;
    ack_ok_nxt = ack_ok_r;
    wr_stb_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    if (stop_cond) begin
      state_nxt = S_IDLE;
      oe_n_nxt = 1'b1;
    end else if (start_cond) begin
      state_nxt = S_ADDR;
      bit_cnt_nxt = 4'h0;
      oe_n_nxt = 1'b1;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          oe_n_nxt = 1'b1;
        end
        S_ADDR, S_CMD, S_WDATA: begin
          if (scl_rise && bit_cnt_r != SMB_BYTE_BITS) begin
            shift_nxt = {shift_r[6:0], sda_s_r};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == SMB_BYTE_BITS) begin
            bit_cnt_nxt = 4'h0;
            oe_n_nxt = 1'b0;
            state_nxt = S_ACK;
            if (state_r == S_ADDR) begin
              after_nxt = shift_r[0] ? S_RDATA : S_CMD;
              if (shift_r[7:1] != DEV_ADDR) begin
                oe_n_nxt = 1'b1;
                state_nxt = S_IDLE;
              end
            end else if (state_r == S_CMD) begin
              cmd_nxt = shift_r;
              after_nxt = S_WDATA;
            end else begin
              wr_stb_nxt = 1'b1;
              wr_addr_nxt = cmd_r;
              wr_data_nxt = shift_r;
              cmd_nxt = cmd_r + 8'h01;
              after_nxt = S_WDATA;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            state_nxt = after_r;
            if (after_r == S_RDATA) begin
              shift_nxt = rd_data;
              oe_n_nxt = rd_data[7];
            end else begin
              oe_n_nxt = 1'b1;
            end
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            if (bit_cnt_r == SMB_BYTE_BITS - 4'h1) begin
              bit_cnt_nxt = 4'h0;
              state_nxt = S_RACK;
            end
          end else if (scl_fall) begin
            shift_nxt = {shift_r[6:0], 1'b0};
            oe_n_nxt = shift_r[6];
          end
        end
        S_RACK: begin
          if (scl_fall && bit_cnt_r == 4'h0) begin
            oe_n_nxt = 1'b1;
            bit_cnt_nxt = 4'h1;
          end else if (scl_rise && bit_cnt_r == 4'h1) begin
            ack_ok_nxt = ~sda_s_r;
            bit_cnt_nxt = 4'h2;
            if (!sda_s_r) begin
              cmd_nxt = cmd_r + 8'h01;
            end
          end else if (scl_fall && bit_cnt_r == 4'h2) begin
            bit_cnt_nxt = 4'h0;
            if (ack_ok_r) begin
              state_nxt = S_RDATA;
              shift_nxt = rd_data;
              oe_n_nxt = rd_data[7];
            end else begin
              state_nxt = S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // slave state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= S_IDLE;
      after_r <= S_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      cmd_r <= 8'h00;
      oe_n_r <= 1'b1;
      ack_ok_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      after_r <= after_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      cmd_r <= cmd_nxt;
      oe_n_r <= oe_n_nxt;
      ack_ok_r <= ack_ok_nxt;
      wr_stb_r <= wr_stb_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe_n = oe_n_r;
  assign rd_addr = cmd_r;
  assign wr_stb = wr_stb_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;
endmodule

//--- wdf_ctrl_properties.sv
`timescale 1ns/1ns
module wdf_ctrl_properties #(
  parameter int TICK_CYCLES = 100
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic SMB_CLK,
  input wire logic SMB_DATA_IN,
  input wire logic SMB_DATA_OE_N,
  input wire logic SYS_REBOOT,
  input wire logic [4:0] FREQ_SELECT,
  input wire logic DIRECT_EN,
  input wire logic [8:0] SYNTH_N,
  input wire logic [6:0] SYNTH_M,
  input wire logic WD_TIMEOUT,
  input wire logic WD_EXPIRE
);
  int gap_r;
  int gap_nxt;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // cycles since the last expiry pulse
  always_comb begin
    gap_nxt = WD_EXPIRE ? 0 : gap_r + 1;
  end
  always_ff @(posedge REF_CLK) begin
    gap_r <= SRST ? 0 : gap_nxt;
  end
  a_expire_single: assert property (WD_EXPIRE |=> !WD_EXPIRE)
    else $error("expiry pulse too long");
  a_expire_flag: assert property (WD_EXPIRE |-> ##[0:1] WD_TIMEOUT)
    else $error("expiry without flag");
  a_flag_cause: assert property ($rose(WD_TIMEOUT) |-> WD_EXPIRE || $past(WD_EXPIRE))
    else $error("flag set without expiry");
  a_flag_clear: assert property ($fell(WD_TIMEOUT) |-> !WD_EXPIRE && !$past(WD_EXPIRE))
    else $error("flag cleared at expiry");
  a_expire_gap: assert property (WD_EXPIRE |-> gap_r >= 2 * TICK_CYCLES - 1)
    else $error("expiry too early");
  a_reset_values: assert property ($fell(SRST) |-> !WD_TIMEOUT && !DIRECT_EN && SYNTH_N == 9'h000
    && SYNTH_M == 7'h00 && FREQ_SELECT == 5'h00 && SMB_DATA_OE_N)
    else $error("outputs not at reset values");
  a_idle_steady: assert property ((SMB_CLK && SMB_DATA_IN && !SYS_REBOOT) [*8]
    |=> $stable({FREQ_SELECT, DIRECT_EN, SYNTH_N, SYNTH_M}))
    else $error("config changed while bus idle");
  a_drive_low_clk: assert property ($changed(SMB_DATA_OE_N) |-> !SMB_CLK)
    else $error("data drive changed with clock high");
endmodule

bind wdf_ctrl_top wdf_ctrl_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.REF_CLK, .SRST, .SMB_CLK,
  .SMB_DATA_IN, .SMB_DATA_OE_N, .SYS_REBOOT, .FREQ_SELECT, .DIRECT_EN, .SYNTH_N, .SYNTH_M,
  .WD_TIMEOUT, .WD_EXPIRE);

//--- wdf_smb_host.sv
`timescale 1ns/1ns
module wdf_smb_host
  import wdf_pkg::*;
(
  input wire logic clk,
  input wire logic sda_w,
  output logic scl_o,
  output logic sda_o
);
  logic [6:0] dev = SMB_DEV_ADDR;
  logic nak = 1'b0;
  // clock and data idle high through the pull-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one bit of 800 ns: data set after the fall, sampled before the next fall
  task bit1(input logic b, output logic r);
    @(posedge clk) sda_o <= b;
    repeat (5) @(posedge clk);
    scl_o <= 1'b1;
    repeat (2) @(posedge clk);
    r = sda_w;
    scl_o <= 1'b0;
  endtask
  // one byte msb first plus the acknowledge slot
  task xb(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], q[i]);
    end
    bit1(ai, ao);
  endtask
  // start or repeated start, late rise so an ack release is not seen as stop
  task sta();
    @(posedge clk) sda_o <= 1'b1;
    repeat (6) @(posedge clk);
    scl_o <= 1'b1;
    repeat (3) @(posedge clk);
    sda_o <= 1'b0;
    repeat (3) @(posedge clk);
    scl_o <= 1'b0;
  endtask
  task sto();
    @(posedge clk) sda_o <= 1'b0;
    repeat (6) @(posedge clk);
    scl_o <= 1'b1;
    repeat (3) @(posedge clk);
    sda_o <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // nak keeps the acknowledge of the address byte
  task wr(input logic [7:0] r, input logic [7:0] d);
    logic [7:0] q;
    logic a;
    sta();
    xb({dev, 1'b0}, 1'b1, q, nak);
    xb(r, 1'b1, q, a);
    xb(d, 1'b1, q, a);
    sto();
  endtask
  task rd(input logic [7:0] r, output logic [7:0] d);
    logic a;
    sta();
    xb({dev, 1'b0}, 1'b1, d, nak);
    xb(r, 1'b1, d, a);
    sta();
    xb({dev, 1'b1}, 1'b1, d, a);
    xb(8'hFF, 1'b1, d, a);
    sto();
  endtask
endmodule

//--- wdf_ctrl_top_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module wdf_ctrl_top_tb;
  localparam int TICK = 100;
  logic clk, srst, reboot, scl, sda_h, oe_n, dout, den, wdt, wde;
  logic [4:0] strap, fsel;
  logic [8:0] syn_n;
  logic [6:0] syn_m;
  logic [7:0] q;
  int err_count = 0;
  int n_checks = 0;
  int n;
  wire sda_w = sda_h & (oe_n | dout);
  // register, written value, expected read value
  logic [23:0] rows [6] = '{24'h0CA5A5, 24'h0DB3B3, 24'h08F515, 24'h0E8181, 24'h205A00, 24'h0B1000};
  wdf_ctrl_top #(.TICK_CYCLES(TICK)) u_wdf_ctrl_top (.REF_CLK(clk), .SRST(srst), .SMB_CLK(scl),
    .SMB_DATA_IN(sda_w), .SMB_DATA_OUT(dout), .SMB_DATA_OE_N(oe_n), .STRAP_FS(strap),
    .SYS_REBOOT(reboot), .FREQ_SELECT(fsel), .DIRECT_EN(den), .SYNTH_N(syn_n), .SYNTH_M(syn_m),
    .WD_TIMEOUT(wdt), .WD_EXPIRE(wde));
  wdf_smb_host u_host (.clk(clk), .sda_w(sda_w), .scl_o(scl), .sda_o(sda_h));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // cycles until the next expiry pulse, capped
  task wexp(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (wde !== 1'b1 && c < 2000);
  endtask
  task reboot_pulse();
    @(posedge clk) reboot <= 1'b1;
    repeat (4) @(posedge clk);
    reboot <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    srst = 1'b1;
    strap = 5'h0B;
    reboot = 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    // rows: N/M above one, test bit written zero
    foreach (rows[i]) begin
      u_host.wr(rows[i][23:16], rows[i][15:8]);
      u_host.rd(rows[i][23:16], q);
      `CHK(q, rows[i][7:0]);
    end
    `CHK({syn_n, syn_m}, {9'h14B, 7'h33});
    `CHK({den, fsel}, 6'h35);
    $display("register rows done");
    // wrong device address is not acknowledged and writes nothing
    u_host.dev ^= 7'h01;
    u_host.wr(8'h0C, 8'h00);
    `CHK(u_host.nak, 1'b1);
    u_host.dev ^= 7'h01;
    u_host.rd(8'h0C, q);
    `CHK({u_host.nak, q}, 9'h0A5);
    u_host.wr(8'h0E, 8'h40);
    `CHK({den, fsel}, 6'h0B);
    $display("address and source done");
    // expiry spacing for period codes 1 to 3
    for (int p = 1; p <= 3; p++) begin
      u_host.wr(8'h0B, 8'(p));
      wexp(n);
      wexp(n);
      `CHK(n, 2 * p * TICK);
      `CHK(wdt, 1'b1);
    end
    u_host.wr(8'h0B, 8'h23); // restart bit 0 then 1
    wexp(n);
    `CHK(n > 540 && n <= 600, 1'b1);
    u_host.wr(8'h0B, 8'h23); // bit already 1: no reload
    wexp(n);
    `CHK(n > 300 && n < 400, 1'b1);
    u_host.rd(8'h0B, q);
    `CHK(q, 8'h33);
    u_host.wr(8'h0B, 8'h20);
    `CHK(wdt, 1'b0);
    wexp(n);
    `CHK(n, 2000);
    $display("watchdog done");
    // reboot with recovery off then on
    @(posedge clk) strap <= 5'h1C;
    u_host.wr(8'h0E, 8'h81);
    reboot_pulse();
    `CHK({den, fsel}, 6'h1C);
    u_host.rd(8'h0E, q);
    `CHK(q, 8'h00);
    u_host.wr(8'h0B, 8'h40);
    u_host.wr(8'h0E, 8'h81);
    reboot_pulse();
    `CHK({den, fsel}, 6'h35);
    $display("reboot done");
    // second reset in mid-run
    @(posedge clk) srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({den, fsel, syn_n, syn_m, wdt}, {6'h1C, 16'h0000, 1'b0});
    `CHK({dout, oe_n, wde}, 3'h2);
    for (int i = 0; i < 4; i++) begin
      u_host.rd(8'(11 + i), q);
      `CHK(q, (i == 3) ? 8'h40 : 8'h00);
    end
    $display("reset done");
    final_report();
  end
endmodule
